//--- rtl/ssrwg_consts.svh
// Named constants of the supervisor reset and write guard block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SSRWG_CONSTS_SVH
`define SSRWG_CONSTS_SVH

// Clock rate and hold times, in MHz and microseconds.
`define SSRWG_CLK_MHZ      10
`define SSRWG_HOLD0_US     50000
`define SSRWG_HOLD1_US     100000
`define SSRWG_HOLD2_US     200000
`define SSRWG_HOLD3_US     400000
`define SSRWG_CNT_W        23

// Wishbone register byte offsets.
`define SSRWG_ADR_W        4
`define SSRWG_ADR_CTRL     4'h0
`define SSRWG_ADR_STATUS   4'h4
`define SSRWG_ADR_MASK     4'h8
`define SSRWG_ADR_LIVE     4'hC

// Control register fields.
`define SSRWG_CTRL_W       4
`define SSRWG_CTRL_RST     4'h0
`define SSRWG_CTRL_HOLD_LO 0
`define SSRWG_CTRL_HOLD_HI 1
`define SSRWG_CTRL_BP_LO   2
`define SSRWG_CTRL_BP_HI   3
`define SSRWG_BP_OPEN      2'h0

// Event bits of the status and mask registers.
`define SSRWG_EV_W         4
`define SSRWG_EV_RST       4'h0
`define SSRWG_EV_RESET     0
`define SSRWG_EV_FAIL2     1
`define SSRWG_EV_FAIL3     2
`define SSRWG_EV_REFUSE    3

// Pin input positions in the synchronised vector.
`define SSRWG_NPIN         5
`define SSRWG_PIN_SUP      0
`define SSRWG_PIN_MON2     1
`define SSRWG_PIN_MON3     2
`define SSRWG_PIN_MAN      3
`define SSRWG_PIN_WP       4
`define SSRWG_PIN_RST      5'h00

`endif

//--- rtl/ssrwg_pkg.sv
// Types shared by the supervisor reset and write guard block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "ssrwg_consts.svh"

package ssrwg_pkg;

	typedef enum logic [1:0] {
		ST_ASSERT = 2'h0,
		ST_HOLD   = 2'h1,
		ST_RUN    = 2'h3
	} ssrwg_state_t;

	typedef struct packed {
		logic valid;
		logic nonvolatile;
	} ssrwg_wr_req_t;

	typedef struct packed {
		logic grant;
		logic refuse;
	} ssrwg_wr_resp_t;

endpackage : ssrwg_pkg

`default_nettype wire

//--- rtl/ssrwg_top.sv
// Supervisor reset sequencer, fail indicators and write guard with a Wishbone slave.
// Assumes one 10 MHz clock, a synchronous active-high reset and comparator results on pins.
`timescale 1ns/1ps
`default_nettype none
`include "ssrwg_consts.svh"

// What this block does
// - Supply reset goes high, open drain, whenever supply is below first threshold.
// - After power-up the supply reset stays high for the selected hold time.
// - Hold duration is chosen by two hold-time bits of the control register.
// - Manual reset request high starts a reset cycle, driving supply reset high.
// - After manual request falls, supply reset stays high for the hold time.
// - Second fail indicator follows second monitor comparison, without hold delay.
// - Third fail indicator follows third monitor comparison, without hold delay.
// - Write-protect high refuses every nonvolatile write.
// - Write-protect with block-protect nonzero refuses all writes, wiper updates included.
// - Write-protect defaults inactive, so protection is off when floating.
// - Manual request forces supply reset high regardless of supply comparison.
module ssrwg_top #(
	parameter int unsigned HOLD0_US = `SSRWG_HOLD0_US,
	parameter int unsigned HOLD1_US = `SSRWG_HOLD1_US,
	parameter int unsigned HOLD2_US = `SSRWG_HOLD2_US,
	parameter int unsigned HOLD3_US = `SSRWG_HOLD3_US,
	parameter int unsigned CNT_W    = `SSRWG_CNT_W
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [`SSRWG_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic                    supply_below_trip_i,
	input  wire logic                    second_monitor_input_i,
	input  wire logic                    third_monitor_input_i,
	input  wire logic                    manual_reset_request_i,
	input  wire logic                    write_protect_i,
	input  wire ssrwg_pkg::ssrwg_wr_req_t  wr_req_i,
	output ssrwg_pkg::ssrwg_wr_resp_t      wr_resp_o,
	output logic                         supply_reset_o,
	output logic                         supply_reset_out_o,
	output logic                         supply_reset_oe_o,
	output logic                         second_fail_indicator_o,
	output logic                         second_fail_out_o,
	output logic                         second_fail_oe_o,
	output logic                         third_fail_indicator_o,
	output logic                         third_fail_out_o,
	output logic                         third_fail_oe_o,
	output logic                         irq_o
);
	import ssrwg_pkg::*;

	localparam logic [CNT_W-1:0] HOLD0_LIM = CNT_W'(HOLD0_US * `SSRWG_CLK_MHZ - 1);
	localparam logic [CNT_W-1:0] HOLD1_LIM = CNT_W'(HOLD1_US * `SSRWG_CLK_MHZ - 1);
	localparam logic [CNT_W-1:0] HOLD2_LIM = CNT_W'(HOLD2_US * `SSRWG_CLK_MHZ - 1);
	localparam logic [CNT_W-1:0] HOLD3_LIM = CNT_W'(HOLD3_US * `SSRWG_CLK_MHZ - 1);

	logic [`SSRWG_NPIN-1:0]   sync1_r;
	logic [`SSRWG_NPIN-1:0]   sync2_r;
	logic [`SSRWG_NPIN-1:0]   sync3_r;
	logic [`SSRWG_NPIN-1:0]   pin_r;
	logic [`SSRWG_CTRL_W-1:0] control_register_r;
	logic [`SSRWG_EV_W-1:0]   status_r;
	logic [`SSRWG_EV_W-1:0]   status_nxt;
	logic [`SSRWG_EV_W-1:0]   mask_r;
	logic [`SSRWG_EV_W-1:0]   event_w;
	logic [`SSRWG_EV_W-1:0]   live_w;
	ssrwg_state_t             state_r;
	ssrwg_state_t             state_nxt;
	logic [CNT_W-1:0]         hold_cnt_r;
	logic [CNT_W-1:0]         hold_lim;
	logic [1:0]               hold_sel;
	logic [1:0]               block_protect;
	logic                     reset_req;
	logic                     reset_r;
	logic                     reset_prev_r;
	logic                     fail2_r;
	logic                     fail3_r;
	logic                     ack_r;
	logic [31:0]              dat_r;
	logic                     bus_take;
	logic                     bus_wr;
	logic                     bus_rd_status;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Pins come from the analogue side, so each passes three flops and a change
	// is accepted only once the second and third stages agree.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= `SSRWG_PIN_RST;
			sync2_r <= `SSRWG_PIN_RST;
			sync3_r <= `SSRWG_PIN_RST;
		end else begin
			sync1_r <= {write_protect_i, manual_reset_request_i, third_monitor_input_i,
				second_monitor_input_i, supply_below_trip_i};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// A floating write-protect pin reads as inactive from reset onward.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_r <= `SSRWG_PIN_RST;
		end else begin
			for (int i = 0; i < `SSRWG_NPIN; i++) begin
				if (sync2_r[i] == sync3_r[i]) begin
					pin_r[i] <= sync3_r[i];
				end
			end
		end
	end

	assign hold_sel      = control_register_r[`SSRWG_CTRL_HOLD_HI:`SSRWG_CTRL_HOLD_LO];
	assign block_protect = control_register_r[`SSRWG_CTRL_BP_HI:`SSRWG_CTRL_BP_LO];
	assign reset_req     = pin_r[`SSRWG_PIN_SUP] | pin_r[`SSRWG_PIN_MAN];

	always_comb begin
		case (hold_sel)
			2'h0:    hold_lim = HOLD0_LIM;
			2'h1:    hold_lim = HOLD1_LIM;
			2'h2:    hold_lim = HOLD2_LIM;
			default: hold_lim = HOLD3_LIM;
		endcase
	end

	// A brown-out restarts the full hold as well, so the host never leaves reset
	// on a supply that has only just recovered.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_ASSERT: begin
				if (!reset_req) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (reset_req) begin
					state_nxt = ST_ASSERT;
				end else if (hold_cnt_r == hold_lim) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (reset_req) begin
					state_nxt = ST_ASSERT;
				end
			end
			default: state_nxt = ST_ASSERT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_HOLD;
			reset_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			reset_r <= (state_nxt != ST_RUN);
		end
	end

	// Software should change the hold select only outside a hold: a limit lowered
	// below the running count lets the counter run on until it wraps.
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r != ST_HOLD || reset_req) begin
			hold_cnt_r <= '0;
		end else if (hold_cnt_r != hold_lim) begin
			hold_cnt_r <= hold_cnt_r + CNT_W'(1);
		end
	end

	// The fail indicators skip the hold sequencer entirely.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail2_r <= 1'b0;
			fail3_r <= 1'b0;
		end else begin
			fail2_r <= pin_r[`SSRWG_PIN_MON2];
			fail3_r <= pin_r[`SSRWG_PIN_MON3];
		end
	end

	// Open-drain pins: the driver pulls low only while the level is low.
	assign supply_reset_o          = reset_r;
	assign supply_reset_out_o      = 1'b0;
	assign supply_reset_oe_o       = ~reset_r;
	assign second_fail_indicator_o = fail2_r;
	assign second_fail_out_o       = 1'b0;
	assign second_fail_oe_o        = ~fail2_r;
	assign third_fail_indicator_o  = fail3_r;
	assign third_fail_out_o        = 1'b0;
	assign third_fail_oe_o         = ~fail3_r;

	// Write guard answers in the same cycle as the request.
	always_comb begin
		wr_resp_o = '0;
		if (wr_req_i.valid) begin
			if (pin_r[`SSRWG_PIN_WP] && block_protect != `SSRWG_BP_OPEN) begin
				wr_resp_o.refuse = 1'b1;
			end else if (pin_r[`SSRWG_PIN_WP] && wr_req_i.nonvolatile) begin
				wr_resp_o.refuse = 1'b1;
			end else begin
				wr_resp_o.grant = 1'b1;
			end
		end
	end

	assign bus_take      = wb_cyc_i & wb_stb_i & ~ack_r;
	assign bus_wr        = bus_take & wb_we_i & wb_sel_i[0];
	assign bus_rd_status = bus_take & ~wb_we_i & (wb_adr_i == `SSRWG_ADR_STATUS);

	always_comb begin
		event_w = '0;
		event_w[`SSRWG_EV_RESET]  = reset_r & ~reset_prev_r;
		event_w[`SSRWG_EV_FAIL2]  = pin_r[`SSRWG_PIN_MON2] & ~fail2_r;
		event_w[`SSRWG_EV_FAIL3]  = pin_r[`SSRWG_PIN_MON3] & ~fail3_r;
		event_w[`SSRWG_EV_REFUSE] = wr_resp_o.refuse;
	end

	// The previous level starts high, so leaving power-on reset raises no event.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_prev_r <= 1'b1;
		end else begin
			reset_prev_r <= reset_r;
		end
	end

	// An event in the cycle of the clearing read still lands in the register.
	assign status_nxt = (status_r & ~({`SSRWG_EV_W{bus_rd_status}})) | event_w;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= `SSRWG_EV_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_register_r <= `SSRWG_CTRL_RST;
			mask_r             <= `SSRWG_EV_RST;
		end else if (bus_wr && wb_adr_i == `SSRWG_ADR_CTRL) begin
			control_register_r <= wb_dat_i[`SSRWG_CTRL_W-1:0];
		end else if (bus_wr && wb_adr_i == `SSRWG_ADR_MASK) begin
			mask_r <= wb_dat_i[`SSRWG_EV_W-1:0];
		end
	end

	assign live_w = {pin_r[`SSRWG_PIN_WP], fail3_r, fail2_r, reset_r};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= bus_take;
			if (bus_take && !wb_we_i) begin
				case (wb_adr_i)
					`SSRWG_ADR_CTRL:   dat_r <= {28'h0000000, control_register_r};
					`SSRWG_ADR_STATUS: dat_r <= {28'h0000000, status_r};
					`SSRWG_ADR_MASK:   dat_r <= {28'h0000000, mask_r};
					`SSRWG_ADR_LIVE:   dat_r <= {28'h0000000, live_w};
					default:           dat_r <= '0;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign irq_o    = |(status_r & mask_r);

	sequence seq_request_gone;
		state_r == ST_ASSERT && !reset_req;
	endsequence

	sequence seq_hold_started;
		state_r == ST_HOLD && hold_cnt_r == '0 && supply_reset_o;
	endsequence

	chk_supply_low_reset: assert property (
		pin_r[`SSRWG_PIN_SUP] |=> supply_reset_o && !supply_reset_oe_o)
		else $error("supply low did not assert reset");

	chk_powerup_hold: assert property (
		$past(rst_i) |-> state_r == ST_HOLD && supply_reset_o && hold_cnt_r == '0)
		else $error("power-up did not start a hold");

	chk_hold_length: assert property (
		$rose(state_r == ST_RUN) |-> $past(hold_cnt_r) == $past(hold_lim) && !supply_reset_o)
		else $error("hold ended at wrong count");

	chk_manual_assert: assert property (
		pin_r[`SSRWG_PIN_MAN] |=> state_r == ST_ASSERT && supply_reset_o)
		else $error("manual request did not assert reset");

	chk_release_hold: assert property (
		seq_request_gone |=> seq_hold_started ##1 supply_reset_o)
		else $error("release did not enter hold");

	chk_fail2_follow: assert property (
		##1 second_fail_indicator_o == $past(pin_r[`SSRWG_PIN_MON2]) && second_fail_oe_o == !second_fail_indicator_o)
		else $error("second fail indicator wrong");

	chk_fail3_follow: assert property (
		##1 third_fail_indicator_o == $past(pin_r[`SSRWG_PIN_MON3]))
		else $error("third fail indicator wrong");

	chk_wp_nonvolatile: assert property (
		wr_req_i.valid && wr_req_i.nonvolatile && pin_r[`SSRWG_PIN_WP] |-> wr_resp_o.refuse && !wr_resp_o.grant)
		else $error("nonvolatile write passed under protect");

	chk_block_protect: assert property (
		wr_req_i.valid && pin_r[`SSRWG_PIN_WP] && block_protect != `SSRWG_BP_OPEN |-> !wr_resp_o.grant ##1 status_r[`SSRWG_EV_REFUSE])
		else $error("write passed under block protect");

	chk_wp_default: assert property (
		$past(rst_i) |-> !pin_r[`SSRWG_PIN_WP] && (wr_req_i.valid -> wr_resp_o.grant))
		else $error("write protect not inactive after reset");

	chk_manual_independent: assert property (
		pin_r[`SSRWG_PIN_MAN] && !pin_r[`SSRWG_PIN_SUP] |=> supply_reset_o [*2])
		else $error("manual request ignored with good supply");

	chk_irq_level: assert property (
		irq_o == |(status_r & mask_r))
		else $error("interrupt level wrong");

	chk_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

endmodule : ssrwg_top

`default_nettype wire

//--- verif/ssrwg_far_side.sv
// Model of the board around the block: pull-ups on the open-drain lines and a pull-down on write protect.
// Assumes the block's output enables are high while it drives a line low.
`timescale 1ns/1ps
`default_nettype none
module ssrwg_far_side (
	input  wire logic reset_oe_i,
	input  wire logic reset_out_i,
	input  wire logic fail2_oe_i,
	input  wire logic fail2_out_i,
	input  wire logic fail3_oe_i,
	input  wire logic fail3_out_i,
	input  wire logic wp_en_i,
	input  wire logic wp_val_i,
	output logic      reset_line_o,
	output logic      fail2_line_o,
	output logic      fail3_line_o,
	output logic      wp_line_o
);
	// A released open-drain line floats up to its pull-up level.
	assign reset_line_o = reset_oe_i ? reset_out_i : 1'b1;
	assign fail2_line_o = fail2_oe_i ? fail2_out_i : 1'b1;
	assign fail3_line_o = fail3_oe_i ? fail3_out_i : 1'b1;
	// An undriven protect pin is pulled low, so writes stay open.
	assign wp_line_o    = wp_en_i ? wp_val_i : 1'b0;
endmodule : ssrwg_far_side
`default_nettype wire

//--- verif/ssrwg_top_test.sv
// Self-checking bench of the supervisor reset and write guard block.
// Assumes the hold parameters are shortened to 10, 20, 30 and 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module ssrwg_top_test;
	import ssrwg_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, sup = 1'b0, mon2 = 1'b0, mon3 = 1'b0;
	logic man = 1'b0, wp_en = 1'b0, wp_val = 1'b0, ack, rst_o, rst_out, rst_oe, f2, f2_out, f2_oe;
	logic f3, f3_out, f3_oe, irq, wp_line, rst_line, f2_line, f3_line;
	logic [3:0] adr = 4'h0, sel = 4'hF;
	logic [31:0] dat = 32'h0, rd, dat_o;
	ssrwg_wr_req_t wr_req = '0;
	ssrwg_wr_resp_t wr_resp;
	int errors = 0, tests_run = 0;
	always #50 clk_i = ~clk_i;
	ssrwg_top #(.HOLD0_US(1), .HOLD1_US(2), .HOLD2_US(3), .HOLD3_US(4), .CNT_W(23)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .supply_below_trip_i(sup),
		.second_monitor_input_i(mon2), .third_monitor_input_i(mon3), .manual_reset_request_i(man),
		.write_protect_i(wp_line), .wr_req_i(wr_req), .wr_resp_o(wr_resp), .supply_reset_o(rst_o),
		.supply_reset_out_o(rst_out), .supply_reset_oe_o(rst_oe), .second_fail_indicator_o(f2),
		.second_fail_out_o(f2_out), .second_fail_oe_o(f2_oe), .third_fail_indicator_o(f3),
		.third_fail_out_o(f3_out), .third_fail_oe_o(f3_oe), .irq_o(irq));
	ssrwg_far_side far_u (.reset_oe_i(rst_oe), .reset_out_i(rst_out), .fail2_oe_i(f2_oe), .fail2_out_i(f2_out),
		.fail3_oe_i(f3_oe), .fail3_out_i(f3_out), .wp_en_i(wp_en), .wp_val_i(wp_val),
		.reset_line_o(rst_line), .fail2_line_o(f2_line), .fail3_line_o(f3_line), .wp_line_o(wp_line));

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
		end
	endtask : check

	// Classic single cycle; the bench never assumes how soon ack comes.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		we  <= 1'b0;
		@(posedge clk_i);
		check({31'h0, ack}, 32'h0, "ack longer than one cycle");
	endtask : wb

	// Counts the cycles for which the supply reset still stands.
	task automatic hold_len(input int lo, input int hi, input string msg);
		int n;
		n = 0;
		while (rst_o === 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		check(32'(n >= lo && n <= hi), 32'h1, msg);
		check({31'h0, rst_line}, 32'h0, "reset line not released");
	endtask : hold_len

	task automatic t_powerup();
		hold_len(10, 18, "power-up hold");
		wb(1'b0, 4'hC, 32'h0);
		check(rd & 32'h8, 32'h0, "floating protect pin reads active");
		$display("done power-up");
	endtask : t_powerup

	task automatic t_manual();
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, 4'h0, 32'(s));
			man <= 1'b1;
			repeat (8) @(posedge clk_i);
			check({31'h0, rst_line}, 32'h1, "manual request not seen");
			man <= 1'b0;
			hold_len(10 * (s + 1) + 1, 10 * (s + 1) + 8, "manual hold length");
		end
		sup <= 1'b1;
		repeat (8) @(posedge clk_i);
		check({30'h0, rst_o, rst_oe}, 32'h2, "supply low not in reset");
		sup <= 1'b0;
		hold_len(41, 48, "brown-out hold");
		$display("done manual and supply");
	endtask : t_manual

	task automatic t_fail();
		logic [1:0] pat [3] = '{2'b10, 2'b01, 2'b00};
		foreach (pat[i]) begin
			mon2 <= pat[i][1];
			mon3 <= pat[i][0];
			repeat (6) @(posedge clk_i);
			check({30'h0, f2, f2_line}, {30'h0, {2{pat[i][1]}}}, "second fail");
			check({30'h0, f3, f3_line}, {30'h0, {2{pat[i][0]}}}, "third fail");
		end
		$display("done fail indicators");
	endtask : t_fail

	task automatic t_irq();
		wb(1'b1, 4'h8, 32'h0);
		wb(1'b0, 4'h4, 32'h0);
		mon2 <= 1'b1;
		repeat (6) @(posedge clk_i);
		check({31'h0, irq}, 32'h0, "masked event raised irq");
		wb(1'b1, 4'h8, 32'h2);
		check({31'h0, irq}, 32'h1, "unmasked event without irq");
		wb(1'b0, 4'h4, 32'h0);
		check(rd, 32'h2, "status content");
		check({31'h0, irq}, 32'h0, "irq after clearing read");
		wb(1'b1, 4'h1, 32'hF);
		wb(1'b0, 4'h1, 32'h0);
		check(rd, 32'h0, "unmapped read");
		sel <= 4'h0;
		wb(1'b1, 4'h8, 32'hF);
		sel <= 4'hF;
		wb(1'b0, 4'h8, 32'h0);
		check(rd, 32'h2, "write with byte lane 0 off took effect");
		mon2 <= 1'b0;
		$display("done interrupt");
	endtask : t_irq

	task automatic t_guard();
		logic exp;
		for (int k = 0; k < 16; k++) begin
			wb(1'b1, 4'h0, {28'h0, 2'(k >> 2), 2'b00});
			wp_en  <= 1'b1;
			wp_val <= k[1];
			repeat (8) @(posedge clk_i);
			exp = k[1] && (k[3:2] != 2'b00 || k[0]);
			wr_req <= '{valid: 1'b1, nonvolatile: k[0]};
			@(negedge clk_i);
			check({30'h0, wr_resp}, {30'h0, !exp, exp}, "write guard answer");
			@(posedge clk_i);
			wr_req <= '0;
		end
		wp_en <= 1'b0;
		wb(1'b0, 4'h4, 32'h0);
		check(rd & 32'h8, 32'h8, "refusal event missing");
		$display("done write guard");
	endtask : t_guard

	task automatic print_verdict();
		$display("tests_run %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_powerup();
		t_manual();
		t_fail();
		t_irq();
		t_guard();
		print_verdict();
	end

	// The whole run needs under 3000 cycles.
	initial begin
		#2000000;
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule : ssrwg_top_test
`default_nettype wire
